/* File: hrt_pkg.sv */
// constants and types of the hibernation and seconds counter block
package hrt_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_COUNTER   = 12'h000;
   localparam logic [11:0] OFF_MATCH0    = 12'h004;
   localparam logic [11:0] OFF_MATCH1    = 12'h008;
   localparam logic [11:0] OFF_LOAD      = 12'h00c;
   localparam logic [11:0] OFF_CONTROL   = 12'h010;
   localparam logic [11:0] OFF_MASK      = 12'h014;
   localparam logic [11:0] OFF_RAW       = 12'h018;
   localparam logic [11:0] OFF_MASKED    = 12'h01c;
   localparam logic [11:0] OFF_CLEAR     = 12'h020;
   localparam logic [11:0] OFF_TRIM      = 12'h024;
   localparam logic [11:0] OFF_DATA_LO   = 12'h030;
   localparam logic [11:0] OFF_DATA_HI   = 12'h12c;
   // word index field of a byte address
   localparam int          ADDR_LSB      = 2;
   localparam int          MEM_WORDS     = 64;
   // clock source and predivider
   localparam logic [6:0]  XTAL_DIV_LAST = 7'h7f;   // divide by 128
   localparam logic [15:0] TRIM_NOMINAL  = 16'h7fff;
   localparam logic [5:0]  TRIM_SLOT     = 6'h3f;   // one second in 64
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // status bit positions
   localparam int          ST_MATCH0     = 0;
   localparam int          ST_MATCH1     = 1;
   localparam int          ST_BATTERY_LOW_FLAG     = 2;
   localparam int          ST_WAKE       = 3;
   localparam int          ST_BITS       = 4;

   // control register, bit 7 down to bit 0
   typedef struct packed {
      logic low_battery_abort;
      logic osc_enable;
      logic battery_monitor_enable;
      logic pin_wake_enable;
      logic match_wake_enable;
      logic osc_source_select;
      logic sleep_request;
      logic counter_enable;
   } hrt_ctrl_t;

   localparam hrt_ctrl_t CTRL_RESET = '0;

   // hibernation state
   typedef enum logic {HRT_RUN, HRT_HIB} hrt_state_t;
endpackage : hrt_pkg

/* File: hrt_hibernate.sv */
// hibernation controller with seconds counter and axi4-lite registers
//
// Operation
// - open-drain power-off low while hibernating
// - wake pin leaves hibernation when enabled
// - wake pin or match restores power
// - wake releases the power-off output
// - reads need no spacing
// - crystal input divided by 128
// - clock source runs only when enabled
// - select 0 crystal, 1 direct oscillator
// - low battery sets raw flag when monitored
// - abort bit refuses hibernation on low battery if monitoring was already on before the sleep write
// - no battery monitoring while hibernating
// - 32-bit seconds counter from predivider
// - trim divides one second in 64
// - higher trim slows, lower trim speeds
// - two match comparators, wake or interrupt
// - counter counts only when enabled
// - load register sets counter any time
// - counter runs regardless of hibernation
// - sleep request starts hibernation after wake setup
// - interrupt sources ORed into one line
// - mask gates sources, clear register clears
`timescale 1ns/1ps
module hrt_hibernate #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // clock source pins
   input  wire logic              osc_in,
   output      logic              osc_out,
   // power and wake pins
   output      logic              power_off_output_n_o,
   output      logic              power_off_output_n_oe,
   input  wire logic              wake_n,
   input  wire logic              battery_below_threshold,
   // interrupt request
   output      logic              irq
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   hrt_pkg::hrt_ctrl_t           ctrl_reg;
   hrt_pkg::hrt_state_t          state_reg;
   logic [31:0]                  seconds_counter_reg;
   logic [31:0]                  match_value_0_reg;
   logic [31:0]                  match_value_1_reg;
   logic [15:0]                  predivider_trim_reg;
   logic [15:0]                  prediv_reg;
   logic [5:0]                   slot_reg;
   logic [6:0]                   xtal_div_reg;
   logic                         osc_prev_reg;
   logic                         osc_out_reg;
   logic [hrt_pkg::ST_BITS-1:0]  raw_status_reg;
   logic [hrt_pkg::ST_BITS-1:0]  interrupt_mask_reg;
   logic                         eq0_prev_reg;
   logic                         eq1_prev_reg;
   logic [31:0]                  retained_memory [hrt_pkg::MEM_WORDS];
   logic                         aw_pend_reg;
   logic                         w_pend_reg;
   logic [ADDR_W-1:0]            aw_addr_reg;
   logic [31:0]                  w_data_reg;
   logic [3:0]                   w_strb_reg;
   logic                         bvalid_reg;
   logic [1:0]                   bresp_reg;
   logic                         rvalid_reg;
   logic [31:0]                  rdata_reg;
   logic [1:0]                   rresp_reg;
   logic                         wr_fire;
   logic                         rd_fire;
   logic [31:0]                  wr_val;
   logic [31:0]                  rd_val;
   logic                         rd_ok;
   logic                         wr_ok;
   logic                         osc_rise;
   logic                         tick;
   logic                         sec_pulse;
   logic                         load_wr;
   logic                         ctrl_wr;
   logic                         clear_wr;
   logic                         hit0;
   logic                         hit1;
   logic                         wake_hit;
   logic                         low_batt;
   logic                         enter_hib;
   logic                         leave_hib;
   logic [hrt_pkg::ST_BITS-1:0]  events;
   hrt_pkg::hrt_ctrl_t           ctrl_wval;
   logic [31:0]                  ctrl_merged;
   logic [31:0]                  trim_merged;

   ////////////////////////////////////////////////////////////////////////////
   // address decode helpers
   function automatic logic is_data(input logic [ADDR_W-1:0] a);
      is_data = (a >= hrt_pkg::OFF_DATA_LO) && (a <= hrt_pkg::OFF_DATA_HI);
   endfunction : is_data

   function automatic logic [5:0] data_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - hrt_pkg::OFF_DATA_LO;
      data_idx = d[hrt_pkg::ADDR_LSB +: 6];
   endfunction : data_idx

   function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
      word_of = {a[ADDR_W-1:hrt_pkg::ADDR_LSB], 2'h0};
   endfunction : word_of

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
      begin
         merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   // write address and data capture, either order
   assign s_axi_awready = !aw_pend_reg;
   assign s_axi_wready  = !w_pend_reg;
   assign wr_fire       = aw_pend_reg && w_pend_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_pend_reg <= 1'b0;
         w_pend_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_pend_reg <= 1'b1;
            aw_addr_reg <= word_of(s_axi_awaddr);
         end
         else if (wr_fire)
            aw_pend_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_pend_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_pend_reg <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= hrt_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? hrt_pkg::RESP_OKAY : hrt_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // write targets
   always_comb
   begin
      wr_ok    = is_data(aw_addr_reg);
      load_wr  = 1'b0;
      ctrl_wr  = 1'b0;
      clear_wr = 1'b0;
      unique case (aw_addr_reg)
         hrt_pkg::OFF_COUNTER, hrt_pkg::OFF_MATCH0, hrt_pkg::OFF_MATCH1,
         hrt_pkg::OFF_MASK, hrt_pkg::OFF_RAW, hrt_pkg::OFF_MASKED,
         hrt_pkg::OFF_TRIM: wr_ok = 1'b1;
         hrt_pkg::OFF_LOAD: begin wr_ok = 1'b1; load_wr = wr_fire; end
         hrt_pkg::OFF_CONTROL: begin wr_ok = 1'b1; ctrl_wr = wr_fire; end
         hrt_pkg::OFF_CLEAR: begin wr_ok = 1'b1; clear_wr = wr_fire; end
         default: ;
      endcase
   end
   assign wr_val    = w_data_reg;
   // merged words cut to their register width on purpose
   assign ctrl_merged = merge({24'h0, ctrl_reg}, wr_val, w_strb_reg);
   assign ctrl_wval   = hrt_pkg::hrt_ctrl_t'(ctrl_merged[7:0]);
   assign trim_merged = merge({16'h0, predivider_trim_reg}, wr_val, w_strb_reg);

   ////////////////////////////////////////////////////////////////////////////
   // reads answered at once
   assign s_axi_arready = !rvalid_reg;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // read mux
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = '0;
      if (is_data(word_of(s_axi_araddr)))
         rd_val = retained_memory[data_idx(word_of(s_axi_araddr))];
      else
         unique case (word_of(s_axi_araddr))
            hrt_pkg::OFF_COUNTER: rd_val = seconds_counter_reg;
            hrt_pkg::OFF_MATCH0:  rd_val = match_value_0_reg;
            hrt_pkg::OFF_MATCH1:  rd_val = match_value_1_reg;
            hrt_pkg::OFF_LOAD:    rd_val = '0;
            hrt_pkg::OFF_CONTROL: rd_val = {24'h0, ctrl_reg};
            hrt_pkg::OFF_MASK:    rd_val = {28'h0, interrupt_mask_reg};
            hrt_pkg::OFF_RAW:     rd_val = {28'h0, raw_status_reg};
            hrt_pkg::OFF_MASKED:  rd_val = {28'h0, raw_status_reg & interrupt_mask_reg};
            hrt_pkg::OFF_CLEAR:   rd_val = '0;
            hrt_pkg::OFF_TRIM:    rd_val = {16'h0, predivider_trim_reg};
            default:              rd_ok  = 1'b0;
         endcase
   end

   // read data register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= hrt_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_val;
         rresp_reg  <= rd_ok ? hrt_pkg::RESP_OKAY : hrt_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg            <= hrt_pkg::CTRL_RESET;
         match_value_0_reg   <= '0;
         match_value_1_reg   <= '0;
         predivider_trim_reg <= hrt_pkg::TRIM_NOMINAL;
         interrupt_mask_reg  <= '0;
      end
      else if (wr_fire)
         unique case (aw_addr_reg)
            hrt_pkg::OFF_CONTROL:
            begin
               ctrl_reg               <= ctrl_wval;
               ctrl_reg.sleep_request <= 1'b0;   // acts once, reads 0
            end
            hrt_pkg::OFF_MATCH0: match_value_0_reg <= merge(match_value_0_reg, wr_val,
                                                            w_strb_reg);
            hrt_pkg::OFF_MATCH1: match_value_1_reg <= merge(match_value_1_reg, wr_val,
                                                            w_strb_reg);
            hrt_pkg::OFF_TRIM: predivider_trim_reg <= trim_merged[15:0];
            hrt_pkg::OFF_MASK: interrupt_mask_reg <= wr_val[hrt_pkg::ST_BITS-1:0];
            default: ;
         endcase
   end

   // retained words, kept through hibernation
   always_ff @(posedge aclk)
   begin
      if (wr_fire && is_data(aw_addr_reg))
         retained_memory[data_idx(aw_addr_reg)] <=
            merge(retained_memory[data_idx(aw_addr_reg)], wr_val, w_strb_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   // source gated by enable
   assign osc_rise = ctrl_reg.osc_enable && osc_in && !osc_prev_reg;
   assign tick = ctrl_reg.osc_source_select ? osc_rise
                 : (osc_rise && (xtal_div_reg == hrt_pkg::XTAL_DIV_LAST));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_prev_reg <= 1'b0;
         xtal_div_reg <= '0;
         osc_out_reg  <= 1'b0;
      end
      else
      begin
         osc_prev_reg <= osc_in;
         osc_out_reg  <= ctrl_reg.osc_enable && !ctrl_reg.osc_source_select && !osc_in;
         if (osc_rise && !ctrl_reg.osc_source_select)
            xtal_div_reg <= xtal_div_reg + 7'h01;
      end
   end
   assign osc_out = osc_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // predivider runs only when enabled
   assign sec_pulse = tick && ctrl_reg.counter_enable && (prediv_reg == 16'h0000);

   // trim loaded when the last slot ends, so used in slot 0; nominal elsewhere
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prediv_reg <= hrt_pkg::TRIM_NOMINAL;
         slot_reg   <= '0;
      end
      else if (sec_pulse)
      begin
         slot_reg   <= slot_reg + 6'h01;
         prediv_reg <= (slot_reg == hrt_pkg::TRIM_SLOT) ? predivider_trim_reg
                       : hrt_pkg::TRIM_NOMINAL;
      end
      else if (tick && ctrl_reg.counter_enable)
         prediv_reg <= prediv_reg - 16'h0001;
   end

   // seconds counter; load any time; runs in any state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         seconds_counter_reg <= '0;
      else if (load_wr)
         seconds_counter_reg <= merge(seconds_counter_reg, wr_val, w_strb_reg);
      else if (sec_pulse)
         seconds_counter_reg <= seconds_counter_reg + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // two comparators, new-match edges
   assign hit0 = (seconds_counter_reg == match_value_0_reg) && !eq0_prev_reg;
   assign hit1 = (seconds_counter_reg == match_value_1_reg) && !eq1_prev_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         eq0_prev_reg <= 1'b1;
         eq1_prev_reg <= 1'b1;
      end
      else
      begin
         eq0_prev_reg <= seconds_counter_reg == match_value_0_reg;
         eq1_prev_reg <= seconds_counter_reg == match_value_1_reg;
      end
   end

   assign wake_hit = !wake_n && ctrl_reg.pin_wake_enable;
   assign low_batt = ctrl_reg.battery_monitor_enable && battery_below_threshold
                     && (state_reg == hrt_pkg::HRT_RUN);

   // event sources
   always_comb
   begin
      events                     = '0;
      events[hrt_pkg::ST_MATCH0] = hit0;
      events[hrt_pkg::ST_MATCH1] = hit1;
      events[hrt_pkg::ST_BATTERY_LOW_FLAG] = low_batt;
      events[hrt_pkg::ST_WAKE]   = wake_hit;
   end

   // sticky raw flags; clear register, set wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         raw_status_reg <= '0;
      else
         raw_status_reg <= (raw_status_reg & ~(clear_wr ? wr_val[hrt_pkg::ST_BITS-1:0]
                                               : '0)) | events;
   end

   assign irq = |(raw_status_reg & interrupt_mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // sleep request with wake source; refused on low battery when the abort bit is set and monitoring was already on before the write
   assign enter_hib = ctrl_wr && ctrl_wval.sleep_request
                      && (ctrl_wval.pin_wake_enable || ctrl_wval.match_wake_enable)
                      && !(ctrl_wval.low_battery_abort && low_batt);
   assign leave_hib = wake_hit || (ctrl_reg.match_wake_enable && (hit0 || hit1));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= hrt_pkg::HRT_RUN;
      else
         unique case (state_reg)
            hrt_pkg::HRT_RUN: if (enter_hib) state_reg <= hrt_pkg::HRT_HIB;
            hrt_pkg::HRT_HIB: if (leave_hib) state_reg <= hrt_pkg::HRT_RUN;
         endcase
   end

   // open drain pulls low in hibernation
   assign power_off_output_n_o  = 1'b0;
   assign power_off_output_n_oe = (state_reg == hrt_pkg::HRT_HIB);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_enter_sleep: assert property (enter_hib && state_reg == hrt_pkg::HRT_RUN
      |=> power_off_output_n_oe) else $error("sleep request not honoured");
   a_abort_low_batt: assert property (state_reg == hrt_pkg::HRT_RUN && ctrl_wr
      && ctrl_wval.low_battery_abort && low_batt |=> !power_off_output_n_oe)
      else $error("hibernation entered on low battery");
   a_wake_pin_exit: assert property (state_reg == hrt_pkg::HRT_HIB && !wake_n
      && ctrl_reg.pin_wake_enable |=> !power_off_output_n_oe)
      else $error("wake pin did not restore power");
   a_match_wake_exit: assert property (state_reg == hrt_pkg::HRT_HIB && hit0
      && ctrl_reg.match_wake_enable |=> state_reg == hrt_pkg::HRT_RUN)
      else $error("match did not restore power");
   a_power_off_cause: assert property ($rose(power_off_output_n_oe)
      |-> $past(ctrl_wr)) else $error("power off without request");
   a_counter_hold: assert property (!ctrl_reg.counter_enable && !load_wr
      |=> $stable(seconds_counter_reg)) else $error("counter moved while off");
   a_second_step: assert property (sec_pulse && !load_wr
      |=> seconds_counter_reg == $past(seconds_counter_reg) + 32'h1)
      else $error("counter step wrong");
   a_load_value: assert property (load_wr && w_strb_reg == 4'hf
      |=> seconds_counter_reg == $past(w_data_reg)) else $error("load not taken");
   a_xtal_gap: assert property (tick && !ctrl_reg.osc_source_select
      |=> !tick [*2]) else $error("crystal tick too close");
   a_clear_set_wins: assert property (clear_wr && events[hrt_pkg::ST_WAKE]
      |=> raw_status_reg[hrt_pkg::ST_WAKE]) else $error("event lost on clear");
   a_no_batt_hib: assert property (state_reg == hrt_pkg::HRT_HIB && !clear_wr
      |=> $stable(raw_status_reg[hrt_pkg::ST_BATTERY_LOW_FLAG])) else $error("monitor in hibernation");
   a_read_answer: assert property (rd_fire |=> s_axi_rvalid)
      else $error("read not answered");

   c_hib_round: cover property (enter_hib ##[1:1000] leave_hib);
   c_second: cover property (sec_pulse);
   c_irq: cover property ($rose(irq));
   c_abort: cover property (ctrl_wr && ctrl_wval.sleep_request && low_batt);

endmodule : hrt_hibernate

/* File: hrt_partner.sv */
// regulator, wake source and oscillator on the far side of the pins
`timescale 1ns/1ps
module hrt_partner (
   // bench controls
   input  wire logic aclk,
   input  wire logic osc_run,
   input  wire logic wake_req,
   // block pins
   input  wire logic pwr_oe,
   input  wire logic pwr_o,
   output      logic osc_in,
   output      logic wake_n,
   // regulator enable level
   output      logic rail_on
);
   // pull-up wins unless the drain pulls low
   assign rail_on = pwr_oe ? pwr_o : 1'b1;
   assign wake_n  = ~wake_req;
   // oscillator stands still until started
   initial osc_in = 1'b0;
   always @(posedge aclk)
   begin
      if (osc_run)
         osc_in <= ~osc_in;
   end
endmodule : hrt_partner

/* File: tb.sv */
// self-checking bench of the hibernation block
`timescale 1ns/1ps
module tb;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic        osc_run = 0, wake_req = 0, batt = 0;
   logic [11:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rv;
   logic        awr, wr_rdy, bv, arr, rvl, osc_in, wake_n, pwr_o, pwr_oe, irq, rail_on;
   logic        osc_out, osc_exp;
   logic [1:0]  bresp, rresp;
   logic [31:0] rd_data;
   logic [34:0] note;
   logic [34:0] notes[$];
   int          err_total = 0;
   int          cmp_count = 0;

   always #5 aclk = ~aclk;

   hrt_hibernate DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_data),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr), .osc_in(osc_in),
      .osc_out(osc_out), .power_off_output_n_o(pwr_o), .power_off_output_n_oe(pwr_oe),
      .wake_n(wake_n), .battery_below_threshold(batt), .irq(irq));

   hrt_partner PARTNER (
      .aclk(aclk), .osc_run(osc_run), .wake_req(wake_req), .pwr_oe(pwr_oe),
      .pwr_o(pwr_o), .osc_in(osc_in), .wake_n(wake_n), .rail_on(rail_on));

   task automatic stop_test(input bit hung);
      if (hung)
         err_total++;
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   function automatic logic [34:0] ok(input logic [31:0] d);
      return {3'h4, d};
   endfunction : ok

   task automatic chk(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      repeat (3) @(posedge aclk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      for (n = 0; n < 40 && !(bv && br); n++)
      begin
         @(posedge aclk);
         if (awr)
            awv <= 1'b0;
         if (wr_rdy)
            wv <= 1'b0;
      end
      br <= 1'b0;
      if (n == 40)
         stop_test(1'b1);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [34:0] exp_note);
      int n;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr  <= 1'b1;
      notes.push_back(exp_note);
      for (n = 0; n < 40 && !(rvl && rr); n++)
      begin
         @(posedge aclk);
         if (arr)
            arv <= 1'b0;
      end
      rr <= 1'b0;
      if (n == 40)
         stop_test(1'b1);
   endtask : rd

   task automatic pulse_wake();
      @(posedge aclk);
      wake_req <= 1'b1;
      repeat (3) @(posedge aclk);
      wake_req <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : pulse_wake

   // oldest note against each read answer
   always @(posedge aclk)
   begin
      if (rvl && rr && notes.size() > 0)
      begin
         note = notes.pop_front();
         cmp_count++;
         if (rresp !== note[33:32] || (note[34] && rd_data !== note[31:0]))
         begin
            err_total++;
            $display("Error rdata expected %h seen %h %h", note, rresp, rd_data);
         end
      end
   end

   // main sequence
   initial
   begin
      void'($urandom(36));
      rv = $urandom();
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(hrt_pkg::OFF_CONTROL, ok(32'h0));
      rd(hrt_pkg::OFF_TRIM, ok(32'h7fff));
      rd(hrt_pkg::OFF_COUNTER, ok(32'h0));
      rd(12'h200, {1'b0, hrt_pkg::RESP_SLVERR, 32'h0});
      wr(hrt_pkg::OFF_TRIM, rv & 32'hffff);
      rd(hrt_pkg::OFF_TRIM, ok(rv & 32'hffff));
      wr(hrt_pkg::OFF_LOAD, rv);
      repeat (20) @(posedge aclk);
      rd(hrt_pkg::OFF_COUNTER, ok(rv));
      wr(hrt_pkg::OFF_DATA_LO, ~rv);
      rd(hrt_pkg::OFF_DATA_LO, ok(~rv));
      rd(hrt_pkg::OFF_DATA_LO, ok(~rv));
      wr(hrt_pkg::OFF_MASK, 32'hf);
      // wake flag follows the pin only with pin wake enabled
      wr(hrt_pkg::OFF_CONTROL, 32'h10);
      pulse_wake();
      rd(hrt_pkg::OFF_RAW, ok(32'h8));
      chk("irq", 1'b1, irq);
      // clear while the pin is still low: the set wins
      wake_req <= 1'b1;
      wr(hrt_pkg::OFF_CLEAR, 32'h8);
      rd(hrt_pkg::OFF_RAW, ok(32'h8));
      wake_req <= 1'b0;
      wr(hrt_pkg::OFF_CLEAR, 32'h8);
      rd(hrt_pkg::OFF_RAW, ok(32'h0));
      chk("irq", 1'b0, irq);
      wr(hrt_pkg::OFF_MASK, 32'h0);
      wr(hrt_pkg::OFF_CONTROL, 32'h44);
      osc_run <= 1'b1;
      wr(hrt_pkg::OFF_CONTROL, 32'h76);
      batt <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("rail_on", 1'b0, rail_on);
      rd(hrt_pkg::OFF_RAW, ok(32'h0));
      batt <= 1'b0;
      pulse_wake();
      chk("rail_on", 1'b1, rail_on);
      chk("irq", 1'b0, irq);
      wr(hrt_pkg::OFF_CLEAR, 32'hf);
      batt <= 1'b1;
      wr(hrt_pkg::OFF_CONTROL, 32'he4);
      rd(hrt_pkg::OFF_RAW, ok(32'h4));
      wr(hrt_pkg::OFF_CONTROL, 32'hf6);
      repeat (2) @(posedge aclk);
      chk("rail_on", 1'b1, rail_on);
      batt <= 1'b0;
      wr(hrt_pkg::OFF_CLEAR, 32'hf);
      wr(hrt_pkg::OFF_MATCH0, rv ^ 32'h5a5a5a5a);
      wr(hrt_pkg::OFF_CONTROL, 32'h4e);
      rd(hrt_pkg::OFF_CONTROL, ok(32'h4c));
      chk("rail_on", 1'b0, rail_on);
      wr(hrt_pkg::OFF_LOAD, rv ^ 32'h5a5a5a5a);
      repeat (2) @(posedge aclk);
      chk("rail_on", 1'b1, rail_on);
      rd(hrt_pkg::OFF_RAW, ok(32'h1));
      // crystal path: drive is the inverse of the sampled input
      wr(hrt_pkg::OFF_CONTROL, 32'h40);
      repeat (300) @(posedge aclk);
      osc_exp = ~osc_in;
      #1 chk("osc_out", osc_exp, osc_out);
      wr(hrt_pkg::OFF_CONTROL, 32'h0);
      #1 chk("osc_out", 1'b0, osc_out);
      // one second is 32768 ticks, a tick every two clocks
      wr(hrt_pkg::OFF_CONTROL, 32'h45);
      repeat (65500) @(posedge aclk);
      rd(hrt_pkg::OFF_COUNTER, ok(rv ^ 32'h5a5a5a5a));
      repeat (100) @(posedge aclk);
      rd(hrt_pkg::OFF_COUNTER, ok((rv ^ 32'h5a5a5a5a) + 32'h1));
      repeat (4) @(posedge aclk);
      stop_test(1'b0);
   end
endmodule : tb
